// [hw/esb_dev.sv]
// Device end: endpoint index and buffer control registers
//
// Overview of operation
// - Indexed accesses follow the index register
// - Index: reserved, setup select, endpoint, direction
// - Setup select picks setup or data buffer
// - Direction zero is OUT, one is IN
// - Decode setup, control and data buffers
// - Software shifts endpoint number into bits 4:1
// - Index never equals DMA endpoint number
// - Wait 190 ns before data port read
// - Wait 100 ns before data port write
// - Control acts on indexed enabled endpoint only
// - Control: reserved, flush, commit, permit, status, stall
// - Flush discards indexed endpoint buffer
// - Receive buffer empties after last byte read
// - One flush clears one of two buffers
// - Commit marks IN data ready to send
// - Full packet commits itself automatically
// - Permit is write-only, NAK until set
// - Firmware sets permit before filling IN
// - Status acknowledge allowed right after setup
// - Permit self-clears on acknowledge, reads zero
// - Status bit NAK/ack, self-clears silently
// - Stall stalls endpoint, not isochronous ones
`include "esb_regs.svh"
`default_nettype none
module esb_dev #(
   parameter int CNT_W = 11
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   esb_if.dev                    bus,
   input  wire logic             usb_bus_reset,
   input  wire logic             ep_enabled,
   input  wire logic             ep_is_iso,
   input  wire logic [CNT_W-1:0] tx_byte_count,
   input  wire logic [CNT_W-1:0] rx_byte_count,
   input  wire logic [CNT_W-1:0] max_packet_size,
   input  wire logic             data_token_acked,
   input  wire logic             status_stage_done,
   input  wire logic             setup_token_seen,
   input  wire logic [7:0]       fifo_rdata,
   output esb_pkg::esb_buf_t     sel_buffer,
   output logic [3:0]            sel_endpoint,
   output logic                  sel_dir,
   output logic                  buffer_flush,
   output logic                  packet_commit,
   output logic                  rx_auto_release,
   output logic                  data_phase_permit,
   output logic                  status_ack,
   output logic [31:0]           stall_mask,
   output logic                  fifo_wr_stb,
   output logic                  fifo_rd_stb,
   output logic [7:0]            fifo_wdata
);
   import esb_pkg::*;

   logic             setup_sel_r;
   logic [3:0]       ep_r;
   logic             dir_r;
   logic             permit_r;
   logic             status_r;
   logic             flush_r;
   logic             commit_r;
   logic             release_r;
   logic             full_seen_r;
   logic [31:0]      stall_r;
   logic [7:0]       rdata_r;
   logic             rvalid_r;
   logic             fifo_wr_r;
   logic             fifo_rd_r;
   logic [7:0]       fifo_wdata_r;
   logic             wr_index;
   logic             wr_ctrl;
   logic             wr_data;
   logic             rd_data;
   logic             ctrl_ok;
   logic [4:0]       sel_entry;
   logic             tx_full;
   esb_buf_t         buf_kind;

   assign wr_index  = bus.wr_stb && (bus.addr == `ESB_OFF_INDEX);
   assign wr_ctrl   = bus.wr_stb && (bus.addr == `ESB_OFF_CTRL);
   assign wr_data   = bus.wr_stb && (bus.addr == `ESB_OFF_DATA_PORT);
   assign rd_data   = bus.rd_stb && (bus.addr == `ESB_OFF_DATA_PORT);
   // Control writes to an unselected or disabled endpoint have nowhere to go
   assign ctrl_ok   = wr_ctrl && ep_enabled;
   assign sel_entry = {ep_r, dir_r};

   // Index register; bus reset keeps the setup select as it was
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         setup_sel_r <= 1'(`ESB_INDEX_RESET >> `ESB_IDX_SETUP_BIT);
         ep_r        <= 4'h0;
         dir_r       <= 1'b0;
      end else if (usb_bus_reset) begin
         ep_r        <= 4'h0;
         dir_r       <= 1'b0;
      end else if (wr_index) begin
         // Bits 7:6 are dropped
         setup_sel_r <= bus.wdata[`ESB_IDX_SETUP_BIT];
         ep_r        <= bus.wdata[`ESB_IDX_EP_MSB:`ESB_IDX_EP_LSB];
         dir_r       <= bus.wdata[`ESB_IDX_DIR_BIT];
      end
   end

   // Buffer decode; setup select only means something on endpoint 0 OUT
   always_comb begin
      if (ep_r == 4'h0 && !dir_r && setup_sel_r) begin
         buf_kind = ESB_BUF_SETUP;
      end else if (ep_r == 4'h0) begin
         buf_kind = dir_r ? ESB_BUF_CTL_IN : ESB_BUF_CTL_OUT;
      end else begin
         buf_kind = dir_r ? ESB_BUF_DATA_IN : ESB_BUF_DATA_OUT;
      end
   end

   assign sel_buffer   = buf_kind;
   assign sel_endpoint = ep_r;
   assign sel_dir      = dir_r;

   // Data phase permit: write-only set, cleared by the acknowledged token
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         permit_r <= 1'b0;
      end else if (usb_bus_reset) begin
         permit_r <= 1'b0;
      end else if (ctrl_ok && bus.wdata[`ESB_CTL_PERMIT_BIT]) begin
         // Firmware setting wins over a token acknowledged the same cycle
         permit_r <= 1'b1;
      end else if (data_token_acked) begin
         permit_r <= 1'b0;
      end
   end

   assign data_phase_permit = permit_r;

   // Status acknowledge; cleared without any interrupt
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_r <= 1'b0;
      end else if (usb_bus_reset) begin
         status_r <= 1'b0;
      end else if (ctrl_ok) begin
         status_r <= bus.wdata[`ESB_CTL_STATUS_BIT];
      end else if (status_stage_done || setup_token_seen) begin
         status_r <= 1'b0;
      end
   end

   assign status_ack = status_r;

   // Stall bit per endpoint and direction
   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_stall
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               stall_r[g] <= 1'b0;
            end else if (usb_bus_reset) begin
               stall_r[g] <= 1'b0;
            end else if (ctrl_ok && !ep_is_iso && sel_entry == 5'(g)) begin
               stall_r[g] <= bus.wdata[`ESB_CTL_STALL_BIT];
            end
         end
      end
   endgenerate

   assign stall_mask = stall_r;

   // Flush: one pulse per command, so a double buffer needs two
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flush_r <= 1'b0;
      end else begin
         flush_r <= ctrl_ok && bus.wdata[`ESB_CTL_FLUSH_BIT];
      end
   end

   assign buffer_flush = flush_r;

   // Packet commit, by software for short packets or when the FIFO fills
   assign tx_full = dir_r && (max_packet_size != '0)
                    && (tx_byte_count == max_packet_size);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         full_seen_r <= 1'b0;
      end else begin
         full_seen_r <= tx_full;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         commit_r <= 1'b0;
      end else begin
         commit_r <= (ctrl_ok && dir_r && bus.wdata[`ESB_CTL_COMMIT_BIT])
                     || (tx_full && !full_seen_r);
      end
   end

   assign packet_commit = commit_r;

   // Reading the last receive byte frees the buffer without a flush
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         release_r <= 1'b0;
      end else begin
         release_r <= rd_data && !dir_r && (rx_byte_count == CNT_W'(1));
      end
   end

   assign rx_auto_release = release_r;

   // Data port passes through to the FIFO of the indexed endpoint
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fifo_wr_r    <= 1'b0;
         fifo_rd_r    <= 1'b0;
         fifo_wdata_r <= 8'h00;
      end else begin
         fifo_wr_r    <= wr_data;
         fifo_rd_r    <= rd_data;
         if (wr_data) begin
            fifo_wdata_r <= bus.wdata;
         end
      end
   end

   assign fifo_wr_stb = fifo_wr_r;
   assign fifo_rd_stb = fifo_rd_r;
   assign fifo_wdata  = fifo_wdata_r;

   // Read answer one cycle after the strobe
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r  <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= bus.rd_stb;
         if (bus.rd_stb) begin
            case (bus.addr)
               `ESB_OFF_INDEX: begin
                  rdata_r <= {2'b00, setup_sel_r, ep_r, dir_r};
               end
               `ESB_OFF_CTRL: begin
                  // Command bits and permit read zero
                  rdata_r <= {6'b000000, status_r, stall_r[sel_entry]};
               end
               `ESB_OFF_DATA_PORT: begin
                  rdata_r <= fifo_rdata;
               end
               default: begin
                  rdata_r <= 8'h00;
               end
            endcase
         end
      end
   end

   assign bus.rdata       = rdata_r;
   assign bus.rdata_valid = rvalid_r;

endmodule : esb_dev
`default_nettype wire

// [hw/esb_if.sv]
// Parallel register interface between microcontroller end and device end
`default_nettype none
interface esb_if;
   logic       wr_stb;
   logic       rd_stb;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       rdata_valid;

   modport dev (input wr_stb, rd_stb, addr, wdata, output rdata, rdata_valid);
   modport mcu (output wr_stb, rd_stb, addr, wdata, input rdata, rdata_valid);
endinterface : esb_if
`default_nettype wire

// [hw/esb_mcu.sv]
// Microcontroller end: APB command registers driving the register interface
`include "esb_regs.svh"
`default_nettype none
module esb_mcu (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [3:0]  dma_endpoint,
   esb_if.mcu               bus
);
   import esb_pkg::*;

   localparam int RdGapCyc = (`ESB_RD_GAP_NS * 1000 + `ESB_CLK_PS - 1) / `ESB_CLK_PS;
   localparam int WrGapCyc = (`ESB_WR_GAP_NS * 1000 + `ESB_CLK_PS - 1) / `ESB_CLK_PS;
   localparam logic [7:0] RdGap   = 8'(RdGapCyc);
   localparam logic [7:0] WrSlack = 8'(RdGapCyc - WrGapCyc);

   esb_host_st_t st_r;
   logic [7:0]   addr_r;
   logic [7:0]   wdata_r;
   logic         read_r;
   logic [7:0]   gap_r;
   logic         loaded_r;
   logic         refused_r;
   logic [7:0]   rd_r;
   logic [31:0]  prdata_r;
   logic         acc;
   logic         cmd_wr;
   logic         stat_wr;
   logic         mapped;
   logic [7:0]   c_addr;
   logic         c_read;
   logic         bad;

   assign acc     = psel && penable;
   assign mapped  = (paddr == `ESB_APB_CMD) || (paddr == `ESB_APB_STAT);
   assign cmd_wr  = acc && pwrite && (paddr == `ESB_APB_CMD);
   assign stat_wr = acc && pwrite && (paddr == `ESB_APB_STAT);
   assign c_addr  = pwdata[`ESB_CMD_ADDR_LSB +: 8];
   assign c_read  = pwdata[`ESB_CMD_READ_BIT];

   // Illegal index values and unindexed control accesses are not sent
   always_comb begin
      bad = 1'b0;
      if (!c_read && c_addr == `ESB_OFF_INDEX) begin
         bad = (pwdata[`ESB_IDX_EP_MSB:`ESB_IDX_EP_LSB] == dma_endpoint)
            || (pwdata[`ESB_IDX_SETUP_BIT]
                && pwdata[`ESB_IDX_DIR_BIT:`ESB_IDX_DIR_BIT] != 1'b0)
            || (pwdata[`ESB_IDX_SETUP_BIT]
                && pwdata[`ESB_IDX_EP_MSB:`ESB_IDX_EP_LSB] != 4'h0);
      end else if (c_addr == `ESB_OFF_CTRL) begin
         bad = !loaded_r;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r    <= ESB_ST_IDLE;
         addr_r  <= 8'h00;
         wdata_r <= 8'h00;
         read_r  <= 1'b0;
         rd_r    <= 8'h00;
      end else begin
         case (st_r)
            ESB_ST_IDLE: begin
               if (cmd_wr && !bad) begin
                  addr_r  <= c_addr;
                  wdata_r <= pwdata[7:0];
                  read_r  <= c_read;
                  st_r    <= ESB_ST_GAP;
               end
            end
            ESB_ST_GAP: begin
               if (addr_r != `ESB_OFF_DATA_PORT) begin
                  st_r <= ESB_ST_ISSUE;
               end else if (read_r ? (gap_r == 8'h00)
                                   : (gap_r <= WrSlack)) begin
                  st_r <= ESB_ST_ISSUE;
               end
            end
            ESB_ST_ISSUE: begin
               st_r <= read_r ? ESB_ST_WAIT_RD : ESB_ST_IDLE;
            end
            ESB_ST_WAIT_RD: begin
               if (bus.rdata_valid) begin
                  rd_r <= bus.rdata;
                  st_r <= ESB_ST_IDLE;
               end
            end
            default: begin
               st_r <= ESB_ST_IDLE;
            end
         endcase
      end
   end

   // Gap timer restarts on every index write
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         gap_r    <= 8'h00;
         loaded_r <= 1'b0;
      end else if (bus.wr_stb && bus.addr == `ESB_OFF_INDEX) begin
         gap_r    <= RdGap;
         loaded_r <= 1'b1;
      end else if (gap_r != 8'h00) begin
         gap_r    <= gap_r - 8'h01;
      end
   end

   // Refusal flag; a new refusal wins over a clear in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         refused_r <= 1'b0;
      end else if (cmd_wr && (bad || st_r != ESB_ST_IDLE)) begin
         refused_r <= 1'b1;
      end else if (stat_wr && pwdata[`ESB_STAT_REFUSE_BIT]) begin
         refused_r <= 1'b0;
      end
   end

   // Read data is captured in the setup cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata_r <= 32'h0000_0000;
         if (paddr == `ESB_APB_STAT) begin
            prdata_r[`ESB_STAT_BUSY_BIT]        <= (st_r != ESB_ST_IDLE);
            prdata_r[`ESB_STAT_REFUSE_BIT]      <= refused_r;
            prdata_r[`ESB_STAT_LOADED_BIT]      <= loaded_r;
            prdata_r[`ESB_STAT_RDATA_LSB +: 8]  <= rd_r;
         end
      end
   end

   assign prdata  = prdata_r;
   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;

   assign bus.wr_stb = (st_r == ESB_ST_ISSUE) && !read_r;
   assign bus.rd_stb = (st_r == ESB_ST_ISSUE) && read_r;
   assign bus.addr   = addr_r;
   assign bus.wdata  = wdata_r;

endmodule : esb_mcu
`default_nettype wire

// [hw/esb_pkg.sv]
// Types for the two ends of the endpoint select and buffer control link
`default_nettype none
package esb_pkg;

   typedef enum logic [2:0] {
      ESB_BUF_SETUP    = 3'b000,
      ESB_BUF_CTL_OUT  = 3'b001,
      ESB_BUF_CTL_IN   = 3'b010,
      ESB_BUF_DATA_OUT = 3'b011,
      ESB_BUF_DATA_IN  = 3'b100
   } esb_buf_t;

   typedef enum logic [1:0] {
      ESB_ST_IDLE    = 2'b00,
      ESB_ST_GAP     = 2'b01,
      ESB_ST_ISSUE   = 2'b10,
      ESB_ST_WAIT_RD = 2'b11
   } esb_host_st_t;

endpackage : esb_pkg
`default_nettype wire

// [hw/esb_regs.svh]
// Register offsets, field positions, reset values and timing figures
`ifndef ESB_REGS_SVH
`define ESB_REGS_SVH

// Offsets on the device's parallel register interface
`define ESB_OFF_DATA_PORT   8'h20
`define ESB_OFF_CTRL        8'h28
`define ESB_OFF_INDEX       8'h2C

// Index register fields
`define ESB_IDX_DIR_BIT     0
`define ESB_IDX_EP_LSB      1
`define ESB_IDX_EP_MSB      4
`define ESB_IDX_SETUP_BIT   5
`define ESB_INDEX_RESET     8'h20

// Control register fields
`define ESB_CTL_STALL_BIT   0
`define ESB_CTL_STATUS_BIT  1
`define ESB_CTL_PERMIT_BIT  2
`define ESB_CTL_COMMIT_BIT  3
`define ESB_CTL_FLUSH_BIT   4
`define ESB_CTRL_RESET      8'h00

// Controller registers on APB
`define ESB_APB_CMD         12'h000
`define ESB_APB_STAT        12'h004
`define ESB_CMD_ADDR_LSB    8
`define ESB_CMD_READ_BIT    16
`define ESB_STAT_BUSY_BIT   0
`define ESB_STAT_REFUSE_BIT 1
`define ESB_STAT_LOADED_BIT 2
`define ESB_STAT_RDATA_LSB  8

// Timing
`define ESB_CLK_PS          4000
`define ESB_RD_GAP_NS       190
`define ESB_WR_GAP_NS       100

`endif

// [test/esb_properties.sv]
// Concurrent checks on the register link joining the two ends
`default_nettype none
module esb_properties (
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       usb_bus_reset,
   input wire logic [3:0] dma_endpoint,
   input wire logic       wr_stb,
   input wire logic       rd_stb,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic       rdata_valid
);
   localparam int RD_GAP = 48;
   localparam int WR_GAP = 25;
   logic [5:0] idx_r;
   logic       loaded_r;
   logic [6:0] gap_r;
   wire logic  idx_wr = wr_stb && addr == 8'h2C;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // Expected index; bus reset keeps only the setup select
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) idx_r <= 6'h20;
      else if (usb_bus_reset) idx_r <= idx_r & 6'h20;
      else if (idx_wr) idx_r <= wdata[5:0];
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) loaded_r <= 1'b0;
      else if (idx_wr) loaded_r <= 1'b1;
   end

   // Saturates so a long idle spell never wraps into a false short gap
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) gap_r <= 7'h7F;
      else if (idx_wr) gap_r <= 7'h01;
      else if (gap_r != 7'h7F) gap_r <= gap_r + 7'h01;
   end

   property p_rd_answer; rd_stb |=> rdata_valid; endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read strobe not answered next cycle");
   property p_idx_read; rd_stb && addr == 8'h2C |=> rdata == {2'b00, idx_r}; endproperty
   a_idx_read: assert property (p_idx_read)
      else $error("index read back wrong");
   property p_ctl_read; rd_stb && addr == 8'h28 |=> rdata[7:2] == 6'h00; endproperty
   a_ctl_read: assert property (p_ctl_read)
      else $error("control read shows command or reserved bits");
   property p_unmapped;
      rd_stb && !(addr inside {8'h20, 8'h28, 8'h2C}) |=> rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_dma_clash; idx_wr |-> wdata[4:1] != dma_endpoint; endproperty
   a_dma_clash: assert property (p_dma_clash)
      else $error("index written with the DMA endpoint");
   property p_setup_legal; idx_wr && wdata[5] |-> wdata[4:0] == 5'h00; endproperty
   a_setup_legal: assert property (p_setup_legal)
      else $error("setup select with other endpoint bits");
   property p_ctl_after_idx; (wr_stb || rd_stb) && addr == 8'h28 |-> loaded_r; endproperty
   a_ctl_after_idx: assert property (p_ctl_after_idx)
      else $error("control access before index load");
   property p_rd_gap; rd_stb && addr == 8'h20 |-> gap_r >= RD_GAP; endproperty
   a_rd_gap: assert property (p_rd_gap)
      else $error("data port read too soon after index write");
   property p_wr_gap; wr_stb && addr == 8'h20 |-> gap_r >= WR_GAP; endproperty
   a_wr_gap: assert property (p_wr_gap)
      else $error("data port write too soon after index write");

   c_idx_wr: cover property (idx_wr);
   c_ctl_wr: cover property (wr_stb && addr == 8'h28);
   c_port_rd: cover property (rd_stb && addr == 8'h20 ##1 rdata_valid);
endmodule : esb_properties
`default_nettype wire

// [test/tb_endpoint_select_buffer_control.sv]
// Bench: APB drives the controller end, which drives the device end
`default_nettype none
module tb_endpoint_select_buffer_control;
   timeunit 1ns;
   timeprecision 100ps;
   import esb_pkg::*;
   logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, err_seen;
   logic        ep_enabled, ep_is_iso, sel_dir, permit, status;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, stall_mask, m_stall;
   logic [3:0]  dma_endpoint, ev, sel_endpoint;
   logic [10:0] tx_cnt, rx_cnt, mps;
   logic [7:0]  fifo_rdata, fifo_wdata;
   logic [5:0]  m_idx;
   logic        m_loaded, m_permit, m_status;
   esb_buf_t    sel_buffer;
   wire logic [4:0] pl;
   int          m_cnt[5];
   int          n_cnt[5];
   int          mismatches, tests_run, cycles;
   integer      seed;

   esb_if link();
   esb_mcu u_esb_mcu (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dma_endpoint(dma_endpoint), .bus(link.mcu));
   esb_dev u_esb_dev (.clk(clk), .reset_n(reset_n), .bus(link.dev), .usb_bus_reset(ev[3]),
      .ep_enabled(ep_enabled), .ep_is_iso(ep_is_iso), .tx_byte_count(tx_cnt),
      .rx_byte_count(rx_cnt), .max_packet_size(mps), .data_token_acked(ev[0]),
      .status_stage_done(ev[1]), .setup_token_seen(ev[2]), .fifo_rdata(fifo_rdata),
      .sel_buffer(sel_buffer), .sel_endpoint(sel_endpoint), .sel_dir(sel_dir),
      .buffer_flush(pl[0]), .packet_commit(pl[1]), .rx_auto_release(pl[2]),
      .data_phase_permit(permit), .status_ack(status), .stall_mask(stall_mask),
      .fifo_wr_stb(pl[3]), .fifo_rd_stb(pl[4]), .fifo_wdata(fifo_wdata));
   esb_properties chk_props (.clk(clk), .reset_n(reset_n), .usb_bus_reset(ev[3]),
      .dma_endpoint(dma_endpoint), .wr_stb(link.wr_stb), .rd_stb(link.rd_stb),
      .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
      .rdata_valid(link.rdata_valid));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Pulses are counted, so the check does not hang on their exact cycle
   always @(posedge clk) begin
      cycles++;
      for (int k = 0; k < 5; k++) n_cnt[k] += int'(pl[k] === 1'b1);
      if (cycles == 30000) begin
         mismatches++;
         stop_test();
      end
   end

   task automatic stop_test();
      if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : chk

   function automatic esb_buf_t exp_buf(input logic [5:0] x);
      if (x[5]) return ESB_BUF_SETUP;
      if (x[4:1] == 4'h0) return x[0] ? ESB_BUF_CTL_IN : ESB_BUF_CTL_OUT;
      return x[0] ? ESB_BUF_DATA_IN : ESB_BUF_DATA_OUT;
   endfunction : exp_buf

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // One command, polled to completion; the refusal flag is cleared after
   task automatic cmd(input logic [7:0] off, input logic [7:0] d, input logic rd,
                      output logic [31:0] st);
      logic [31:0] q;
      apb(1'b1, 12'h000, {15'h0000, rd, off, d}, q);
      do begin
         apb(1'b0, 12'h004, 32'h0, st);
      end while (st[0] !== 1'b0);
      apb(1'b1, 12'h004, 32'h2, q);
   endtask : cmd

   task automatic check_state();
      chk("sel_endpoint", sel_endpoint, m_idx[4:1]);
      chk("sel_dir", sel_dir, m_idx[0]);
      chk("sel_buffer", sel_buffer, exp_buf(m_idx));
      chk("permit", permit, m_permit);
      chk("status", status, m_status);
      chk("stall", stall_mask, m_stall);
      for (int k = 0; k < 5; k++) chk("pulses", n_cnt[k], m_cnt[k]);
   endtask : check_state

   task automatic set_index(input logic [7:0] v);
      logic [31:0] st;
      logic        bad;
      cmd(8'h2C, v, 1'b0, st);
      bad = v[4:1] == dma_endpoint || (v[5] && v[4:0] != 5'h00);
      chk("index_refused", st[1], bad);
      if (!bad) begin
         m_idx = v[5:0];
         m_loaded = 1'b1;
      end
      cmd(8'h2C, 8'h00, 1'b1, st);
      chk("index_read", st[15:8], m_idx);
      check_state();
   endtask : set_index

   task automatic ctl_write(input logic [7:0] v);
      logic [31:0] st;
      cmd(8'h28, v, 1'b0, st);
      chk("ctl_refused", st[1], !m_loaded);
      if (m_loaded && ep_enabled) begin
         m_cnt[0] += v[4];
         m_cnt[1] += v[3] & m_idx[0];
         m_permit |= v[2];
         m_status = v[1];
         if (!ep_is_iso) m_stall[m_idx[4:0]] = v[0];
      end
      if (m_loaded) begin
         cmd(8'h28, 8'h00, 1'b1, st);
         chk("ctl_read", st[15:8], {6'h00, m_status, m_stall[m_idx[4:0]]});
      end
      check_state();
   endtask : ctl_write

   task automatic hw_event(input int b);
      logic [31:0] st;
      @(posedge clk);
      ev[b] <= 1'b1;
      @(posedge clk);
      ev <= 4'h0;
      if (b == 0) m_permit = 1'b0;
      else if (b < 3) m_status = 1'b0;
      else begin
         m_idx &= 6'h20;
         m_permit = 1'b0;
         m_status = 1'b0;
         m_stall = 32'h0;
      end
      cmd(8'h2C, 8'h00, 1'b1, st);
      chk("index_read", st[15:8], m_idx);
      check_state();
   endtask : hw_event

   task automatic data_port(input logic rd, input logic [10:0] rx);
      logic [31:0] st;
      logic [7:0]  b;
      b = 8'($random(seed));
      rx_cnt <= rx;
      fifo_rdata <= b;
      cmd(8'h20, b, rd, st);
      if (rd) begin
         chk("port_read", st[15:8], b);
         m_cnt[4]++;
         m_cnt[2] += int'(!m_idx[0] && rx == 11'h001);
      end else begin
         chk("port_wdata", fifo_wdata, b);
         m_cnt[3]++;
      end
      check_state();
   endtask : data_port

   task automatic reset_dut();
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      m_idx = 6'h20;
      m_loaded = 1'b0;
      m_permit = 1'b0;
      m_status = 1'b0;
      m_stall = 32'h0;
   endtask : reset_dut

   initial begin
      logic [7:0]  tbl [5] = '{8'h20, 8'h01, 8'h02, 8'h3F, 8'h1E};
      logic [7:0]  v;
      logic [31:0] st;
      seed = 32'hB2AF529B;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {ev, ep_enabled, ep_is_iso, tx_cnt, rx_cnt, fifo_rdata} = '0;
      dma_endpoint = 4'hF;
      mps = 11'h008;
      reset_dut();
      check_state();
      ctl_write(8'h16);
      for (int i = 0; i < 14; i++) begin
         v = i < 5 ? tbl[i] : 8'($random(seed));
         dma_endpoint <= i < 5 ? 4'hF : 4'($random(seed));
         set_index(v);
      end
      dma_endpoint <= 4'hF;
      ep_enabled <= 1'b1;
      set_index(8'h01);
      for (int b = 0; b < 5; b++) ctl_write(8'hE0 | 8'(1 << b));
      ctl_write(8'h10);
      ctl_write(8'h04);
      data_port(1'b0, 11'h000);
      ctl_write(8'h08);
      hw_event(0);
      ctl_write(8'h02);
      hw_event(1);
      ctl_write(8'h02);
      hw_event(2);
      ctl_write(8'h02);
      ep_is_iso <= 1'b1;
      ctl_write(8'h01);
      ep_is_iso <= 1'b0;
      ep_enabled <= 1'b0;
      ctl_write(8'h1F);
      ep_enabled <= 1'b1;
      set_index(8'h02);
      ctl_write(8'h09);
      data_port(1'b1, 11'h003);
      data_port(1'b1, 11'h001);
      set_index(8'h03);
      data_port(1'b0, 11'h000);
      for (int c = 1; c < 13; c++) begin
         @(posedge clk);
         tx_cnt <= 11'(c);
      end
      m_cnt[1]++;
      repeat (2) @(posedge clk);
      check_state();
      hw_event(3);
      cmd(8'h30, 8'h00, 1'b1, st);
      chk("unmapped", st[15:8], 32'h0);
      // Second command lands while the first read is still in flight
      apb(1'b1, 12'h000, 32'h0001_2C00, st);
      apb(1'b1, 12'h000, 32'h0001_2C00, st);
      apb(1'b0, 12'h004, 32'h0, st);
      chk("busy_refused", st[1], 32'h1);
      apb(1'b1, 12'h008, 32'hFFFFFFFF, st);
      chk("pslverr", err_seen, 32'h1);
      reset_dut();
      ctl_write(8'h01);
      stop_test();
   end
endmodule : tb_endpoint_select_buffer_control
`default_nettype wire
